// >>> src/i2crs_params.svh
// Constants shared by both ends of the two-wire register port.
// Assumes inclusion by bare name from the package and both ends.
`ifndef I2CRS_PARAMS_SVH
`define I2CRS_PARAMS_SVH

// --------------------------------------------------------------------
// Device register map (pointer values)
// --------------------------------------------------------------------
`define I2CRS_PTR_STATUS0 8'h00
`define I2CRS_PTR_DATA0 8'h02
`define I2CRS_NUM_STATUS 2
`define I2CRS_NUM_DATA 4
`define I2CRS_DATA_RESET 8'h00
`define I2CRS_UNMAPPED_READ 8'h00
`define I2CRS_SLAVE_ADDR 7'h2a

// --------------------------------------------------------------------
// Link timing
// --------------------------------------------------------------------
`define I2CRS_CLK_PERIOD_NS 40
`define I2CRS_SCL_PERIOD_NS 640
`define I2CRS_SCL_QUARTER (`I2CRS_SCL_PERIOD_NS / (4 * `I2CRS_CLK_PERIOD_NS))

// --------------------------------------------------------------------
// Controller registers on the AXI4-Lite side
// --------------------------------------------------------------------
`define I2CRS_AXI_ADDR_W 8
`define I2CRS_REG_CTRL 8'h00
`define I2CRS_REG_TARGET 8'h04
`define I2CRS_REG_WDATA 8'h08
`define I2CRS_REG_RDATA 8'h0c
`define I2CRS_REG_STATUS 8'h10
`define I2CRS_CTRL_GO 0
`define I2CRS_CTRL_READ 1
`define I2CRS_CTRL_LEN_LSB 2
`define I2CRS_TARGET_CHIP_LSB 0
`define I2CRS_TARGET_PTR_LSB 8
`define I2CRS_STATUS_BUSY 0
`define I2CRS_STATUS_NACK 1
`define I2CRS_RESP_OKAY 2'b00
`define I2CRS_RESP_SLVERR 2'b10

`endif

// >>> src/i2crs_pkg.sv
// Types shared by both ends of the two-wire register port.
// Assumes i2crs_params.svh on the include path.
`include "i2crs_params.svh"

package i2crs_pkg;

  // ------------------------------------------------------------------
  // Data types
  // ------------------------------------------------------------------
  typedef logic [7:0] i2crs_byte_t;
  typedef logic [`I2CRS_NUM_STATUS-1:0][7:0] i2crs_status_t;
  typedef logic [`I2CRS_NUM_DATA-1:0][7:0] i2crs_ctrl_t;
  typedef logic [3:0][7:0] i2crs_word_t;

  // ------------------------------------------------------------------
  // State machines
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    D_IDLE, D_RX_BIT, D_RX_ACK_WAIT, D_RX_ACK, D_TX_BIT, D_TX_ACK,
    D_IGNORE
  } i2crs_dev_state_e;

  typedef enum logic [2:0] {
    H_IDLE, H_START, H_TX, H_RX, H_STOP
  } i2crs_host_state_e;

endpackage

// >>> src/i2crs_if.sv
// Two-wire link between the controller end and the device end.
// Both lines are open drain with pull-ups; the wire level is resolved here.
`timescale 1ns/100ps

interface i2crs_if;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Pull-up wins unless an enabled driver pulls low
  assign scl = ~(host_scl_oe & ~host_scl_out);
  assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));

  modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_out,
                output host_scl_oe, output host_sda_out, output host_sda_oe);
endinterface

// >>> src/i2crs_host.sv
// Controller end: AXI4-Lite registers drive a two-wire bus master.
// Assumes one clock; SCL is made here by a divider, no clock stretching.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`include "i2crs_params.svh"

module i2crs_host #(
  parameter int QUARTER = `I2CRS_SCL_QUARTER
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [`I2CRS_AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [`I2CRS_AXI_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  i2crs_if.host link
);
  import i2crs_pkg::*;

  if (QUARTER < 2) begin : g_chk
    $error("QUARTER must be at least 2");
  end

  function automatic logic reg_known(input logic [`I2CRS_AXI_ADDR_W-1:0] a);
    return a == `I2CRS_REG_CTRL || a == `I2CRS_REG_TARGET ||
           a == `I2CRS_REG_WDATA || a == `I2CRS_REG_RDATA ||
           a == `I2CRS_REG_STATUS;
  endfunction

  // ------------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------------
  logic aw_got, w_got, cfg_read, busy, nack;
  logic [`I2CRS_AXI_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [1:0] cfg_len;
  logic [6:0] chip;
  i2crs_byte_t ptr;
  i2crs_word_t wdata, rdata;
  logic do_write, start_req;

  assign s_axi_awready_out = ~aw_got;
  assign s_axi_wready_out = ~w_got;
  assign s_axi_arready_out = ~s_axi_rvalid_out;
  assign do_write = aw_got & w_got & ~s_axi_bvalid_out;
  assign start_req = do_write & (aw_addr == `I2CRS_REG_CTRL) & w_strb[0] &
                     w_data[`I2CRS_CTRL_GO] & ~busy;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `I2CRS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && !aw_got) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_got) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= reg_known(aw_addr) ? `I2CRS_RESP_OKAY :
                                                `I2CRS_RESP_SLVERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // Settings frozen while a transfer runs
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_read <= 1'b0;
      cfg_len <= '0;
      chip <= '0;
      ptr <= '0;
      wdata <= '0;
    end else if (do_write && !busy) begin
      if (aw_addr == `I2CRS_REG_CTRL && w_strb[0]) begin
        cfg_read <= w_data[`I2CRS_CTRL_READ];
        cfg_len <= w_data[`I2CRS_CTRL_LEN_LSB +: 2];
      end
      if (aw_addr == `I2CRS_REG_TARGET && w_strb[0]) begin
        chip <= w_data[`I2CRS_TARGET_CHIP_LSB +: 7];
      end
      if (aw_addr == `I2CRS_REG_TARGET && w_strb[1]) begin
        ptr <= w_data[`I2CRS_TARGET_PTR_LSB +: 8];
      end
      if (aw_addr == `I2CRS_REG_WDATA) begin
        for (int i = 0; i < 4; i++) begin
          if (w_strb[i]) begin
            wdata[i] <= w_data[8*i +: 8];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= `I2CRS_RESP_OKAY;
    end else if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= reg_known(s_axi_araddr_in) ? `I2CRS_RESP_OKAY :
                                                      `I2CRS_RESP_SLVERR;
      unique case (s_axi_araddr_in)
        `I2CRS_REG_CTRL: s_axi_rdata_out <= {28'h0000000, cfg_len,
                                             cfg_read, 1'b0};
        `I2CRS_REG_TARGET: s_axi_rdata_out <= {16'h0000, ptr, 1'b0, chip};
        `I2CRS_REG_WDATA: s_axi_rdata_out <= wdata;
        `I2CRS_REG_RDATA: s_axi_rdata_out <= rdata;
        `I2CRS_REG_STATUS: s_axi_rdata_out <= {30'h00000000, nack, busy};
        default: s_axi_rdata_out <= '0;
      endcase
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Bus master
  // ------------------------------------------------------------------
  logic [1:0] sda_sync;
  logic [15:0] qcnt;
  logic tick;
  logic [1:0] q;
  logic [3:0] bitc;
  logic [2:0] byte_no, count;
  logic second, acked, scl_low, sda_low;
  i2crs_byte_t txsh, rxsh;
  i2crs_host_state_e state;

  assign count = {1'b0, cfg_len} + 3'h1;
  assign tick = (qcnt == 16'(QUARTER - 1));
  assign link.host_scl_out = 1'b0;
  assign link.host_scl_oe = scl_low;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe = sda_low;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sda_sync <= 2'b11;
      qcnt <= '0;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
      qcnt <= tick ? 16'h0000 : qcnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= H_IDLE;
      q <= '0;
      bitc <= '0;
      byte_no <= '0;
      second <= 1'b0;
      acked <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      txsh <= '0;
      rxsh <= '0;
      rdata <= '0;
      busy <= 1'b0;
      nack <= 1'b0;
    end else if (state == H_IDLE) begin
      if (start_req) begin
        busy <= 1'b1;
        nack <= 1'b0;
        second <= 1'b0;
        q <= '0;
        state <= H_START;
      end
    end else if (tick) begin
      q <= q + 2'd1;
      unique case (state)
        H_START: begin
          if (q == 2'd1) sda_low <= 1'b1; // [R2]
          if (q == 2'd3) begin
            scl_low <= 1'b1;
            bitc <= '0;
            byte_no <= '0;
            txsh <= {chip, second}; // [R12] [R16]
            state <= H_TX;
          end
        end
        H_TX, H_RX: begin
          // Data moves one quarter after SCL falls [R1]
          if (q == 2'd0) begin
            if (bitc != 4'd8) begin
              sda_low <= (state == H_TX) ? ~txsh[7] : 1'b0; // [R6]
            end else if (state == H_TX) begin
              sda_low <= 1'b0; // [R7]
            end else begin
              sda_low <= (byte_no != count); // [R18]
            end
          end
          if (q == 2'd1) scl_low <= 1'b0;
          if (q == 2'd2) begin
            if (bitc != 4'd8) rxsh <= {rxsh[6:0], sda_sync[1]};
            else acked <= ~sda_sync[1]; // Ack never skipped [R11]
          end
          if (q == 2'd3) begin
            scl_low <= 1'b1;
            if (bitc != 4'd8) begin // [R5]
              bitc <= bitc + 4'd1;
              txsh <= {txsh[6:0], 1'b0};
            end else begin
              bitc <= '0;
              byte_no <= byte_no + 3'd1;
              if (state == H_RX) begin
                rdata[2'(byte_no - 3'd1)] <= rxsh;
                if (byte_no == count) state <= H_STOP;
              end else if (!acked) begin
                nack <= 1'b1; // [R9]
                state <= H_STOP;
              end else if (second) begin
                state <= H_RX;
              end else if (byte_no == 3'd0) begin
                txsh <= ptr;
              end else if (cfg_read || byte_no == count + 3'd1) begin
                state <= H_STOP; // [R15] [R16]
              end else begin
                txsh <= wdata[2'(byte_no - 3'd1)];
              end
            end
          end
        end
        H_STOP: begin
          if (q == 2'd0) sda_low <= 1'b1;
          if (q == 2'd1) scl_low <= 1'b0;
          if (q == 2'd2) sda_low <= 1'b0; // [R3]
          if (q == 2'd3) begin
            // Stop always precedes the next start [R4]
            if (cfg_read && !second && !nack) begin
              second <= 1'b1;
              state <= H_START;
            end else begin
              busy <= 1'b0;
              state <= H_IDLE;
            end
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

endmodule

// >>> src/i2crs_device.sv
// Device end: two-wire slave port onto six byte registers.
// Assumes SCL from the controller, sampled by clk_in at 8 or more
// cycles per SCL period; lockout is a pin, status comes from logic.
//
// Function
// R1 - SDA changes only while SCL low
// R2 - SDA falling, SCL high means start
// R3 - SDA rising, SCL high means stop
// R4 - Controller sends stop before every start
// R5 - Eight bits then one acknowledge slot
// R6 - Most significant bit goes first
// R7 - Controller releases SDA during acknowledge slot
// R8 - Addressed device pulls SDA low on acknowledge
// R9 - No acknowledge leaves SDA high; stop aborts
// R10 - No acknowledge while supply lockout active
// R11 - Controller may skip checking the acknowledge
// R12 - Write: start, address, pointer, data, stop
// R13 - Write data lands at successive pointer addresses
// R14 - Acknowledge address, pointer and every data byte
// R15 - Write starts anywhere, stop ends storing
// R16 - Read: set pointer, stop, then address read
// R17 - Send pointed bytes while controller acknowledges
// R18 - Controller ends read with high acknowledge, stop
// R19 - Reads start at any stored pointer
// R20 - First status register at pointer zero
// R21 - First data register at pointer two
// R22 - Data register reads return last written byte
// R23 - Ignore transfer on chip address mismatch
`timescale 1ns/100ps
`include "i2crs_params.svh"

module i2crs_device #(
  parameter logic [6:0] SLAVE_ADDR = `I2CRS_SLAVE_ADDR
) (
  input wire logic clk_in,
  input wire logic rst_in,
  i2crs_if.dev link,
  input wire logic uvlo_in,
  input wire i2crs_pkg::i2crs_status_t status_in,
  output i2crs_pkg::i2crs_ctrl_t control_out,
  output logic busy_out
);
  import i2crs_pkg::*;

  if (SLAVE_ADDR == 7'h00) begin : g_chk
    $error("SLAVE_ADDR zero is the general call address");
  end

  // ------------------------------------------------------------------
  // Register map helpers
  // ------------------------------------------------------------------
  function automatic logic is_data(input i2crs_byte_t p);
    return p >= `I2CRS_PTR_DATA0 &&
           p < `I2CRS_PTR_DATA0 + 8'(`I2CRS_NUM_DATA); // [R21]
  endfunction

  function automatic logic is_status(input i2crs_byte_t p);
    return p >= `I2CRS_PTR_STATUS0 &&
           p < `I2CRS_PTR_STATUS0 + 8'(`I2CRS_NUM_STATUS); // [R20]
  endfunction

  logic [1:0] da_base_sum;
  i2crs_ctrl_t data_regs;

  // Unmapped pointers read a fixed byte rather than aliasing
  function automatic i2crs_byte_t read_reg(input i2crs_byte_t p,
                                           input i2crs_status_t st,
                                           input i2crs_ctrl_t dr);
    i2crs_byte_t off;
    off = 8'h00;
    if (is_status(p)) begin
      off = p - `I2CRS_PTR_STATUS0;
      return st[off[0]];
    end
    if (is_data(p)) begin
      off = p - `I2CRS_PTR_DATA0;
      return dr[off[1:0]]; // [R22]
    end
    return `I2CRS_UNMAPPED_READ;
  endfunction

  // ------------------------------------------------------------------
  // Pin synchronisers and bus conditions
  // ------------------------------------------------------------------
  logic [1:0] scl_sync, sda_sync, uvlo_sync;
  logic scl_prev, sda_prev;
  logic scl_s, sda_s, uvlo;
  logic start_seen, stop_seen, scl_rise, scl_fall;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      uvlo_sync <= 2'b11;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      uvlo_sync <= {uvlo_sync[0], uvlo_in};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign uvlo = uvlo_sync[1];
  assign start_seen = scl_prev & scl_s & sda_prev & ~sda_s; // [R2]
  assign stop_seen = scl_prev & scl_s & ~sda_prev & sda_s; // [R3]
  assign scl_rise = ~scl_prev & scl_s;
  assign scl_fall = scl_prev & ~scl_s;

  // ------------------------------------------------------------------
  // Byte engine
  // ------------------------------------------------------------------
  i2crs_dev_state_e state;
  i2crs_byte_t shreg, ptr, rd_byte;
  logic [2:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic is_read, master_acked, sda_low, wr_en;

  assign rd_byte = read_reg(ptr, status_in, data_regs);
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = sda_low;
  assign busy_out = (state != D_IDLE) && (state != D_IGNORE);

  // Store only acknowledged data bytes of a write [R13] [R15]
  assign wr_en = !start_seen && !stop_seen && state == D_RX_ACK_WAIT &&
                 scl_fall && byte_cnt == 2'd2 && !uvlo;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= D_IDLE;
      shreg <= '0;
      ptr <= `I2CRS_PTR_STATUS0;
      bit_cnt <= '0;
      byte_cnt <= '0;
      is_read <= 1'b0;
      master_acked <= 1'b0;
      sda_low <= 1'b0;
    end else if (stop_seen) begin
      state <= D_IDLE; // [R9] [R15]
      sda_low <= 1'b0;
    end else if (start_seen) begin
      state <= D_RX_BIT;
      bit_cnt <= '0;
      byte_cnt <= '0;
      sda_low <= 1'b0;
    end else begin
      unique case (state)
        D_IDLE, D_IGNORE: sda_low <= 1'b0;
        D_RX_BIT: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s}; // [R6]
            bit_cnt <= bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) state <= D_RX_ACK_WAIT; // [R5]
          end
        end
        D_RX_ACK_WAIT: begin
          // Ack is driven only after SCL falls [R1]
          if (scl_fall) begin
            if (uvlo) begin
              state <= D_IGNORE; // [R10]
            end else if (byte_cnt == 2'd0) begin
              if (shreg[7:1] == SLAVE_ADDR) begin
                sda_low <= 1'b1; // [R8] [R14]
                is_read <= shreg[0];
                byte_cnt <= 2'd1;
                state <= D_RX_ACK;
              end else begin
                state <= D_IGNORE; // [R23]
              end
            end else begin
              sda_low <= 1'b1; // [R14]
              state <= D_RX_ACK;
              byte_cnt <= 2'd2;
              if (byte_cnt == 2'd1) ptr <= shreg; // [R15] [R19]
              else ptr <= ptr + 8'h01; // [R13]
            end
          end
        end
        D_RX_ACK: begin
          if (scl_fall) begin
            bit_cnt <= '0;
            if (is_read) begin
              shreg <= rd_byte; // [R17] [R19]
              sda_low <= ~rd_byte[7];
              ptr <= ptr + 8'h01;
              state <= D_TX_BIT;
            end else begin
              sda_low <= 1'b0;
              state <= D_RX_BIT;
            end
          end
        end
        D_TX_BIT: begin
          if (scl_fall) begin
            if (bit_cnt == 3'd7) begin
              sda_low <= 1'b0;
              state <= D_TX_ACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0}; // [R6]
              sda_low <= ~shreg[6];
              bit_cnt <= bit_cnt + 3'd1;
            end
          end
        end
        D_TX_ACK: begin
          if (scl_rise) master_acked <= ~sda_s;
          if (scl_fall) begin
            bit_cnt <= '0;
            if (master_acked) begin
              shreg <= rd_byte; // [R17]
              sda_low <= ~rd_byte[7];
              ptr <= ptr + 8'h01;
              state <= D_TX_BIT;
            end else begin
              state <= D_IGNORE;
            end
          end
        end
        default: state <= D_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Data registers
  // ------------------------------------------------------------------
  // Writes to status or unmapped pointers are acknowledged but dropped
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      data_regs <= {`I2CRS_NUM_DATA{`I2CRS_DATA_RESET}};
    end else if (wr_en && is_data(ptr)) begin
      data_regs[da_base_sum] <= shreg; // [R13] [R22]
    end
  end

  assign da_base_sum = 2'(ptr - `I2CRS_PTR_DATA0);
  assign control_out = data_regs;

endmodule

// >>> dv/i2crs_asserts.sv
// Checks on the two-wire link between controller and device ends.
// Assumes the resolved wire levels and enables of i2crs_if.
`timescale 1ns/100ps
`include "i2crs_params.svh"

module i2crs_asserts #(
  parameter logic [6:0] SLAVE_ADDR = `I2CRS_SLAVE_ADDR
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic uvlo_in
);
  logic scl_q, sda_q, in_frame, first, rd, ign, lock, ack, ack_rd, ack_ign;
  logic start, stop, rise, mism;
  logic [3:0] cnt;
  logic [7:0] shreg;
  // ------------------------------------------------------------------
  // Bus tracking
  // ------------------------------------------------------------------
  assign start = scl_q & scl & sda_q & ~sda;
  assign stop = scl_q & scl & ~sda_q & sda;
  assign rise = ~scl_q & scl;
  assign mism = first & (shreg[7:1] != SLAVE_ADDR);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      in_frame <= start | (in_frame & ~stop);
    end
  end
  // Lockout taken at start only; bench never toggles it mid-transfer
  always_ff @(posedge clk_in) begin
    if (rst_in || start) begin
      cnt <= 4'h0;
      ack <= 1'b0;
      first <= 1'b1;
      rd <= 1'b0;
      ign <= 1'b0;
      lock <= uvlo_in & ~rst_in;
      ack_rd <= 1'b0;
      ack_ign <= 1'b0;
    end else if (rise) begin
      shreg <= {shreg[6:0], sda};
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      ack <= (cnt == 4'h8);
      if (cnt == 4'h8) begin
        ack_rd <= ~first & rd;
        ack_ign <= ign | mism | lock;
        rd <= first ? shreg[0] : rd;
        ign <= ign | mism | lock;
        first <= 1'b0;
      end
    end else if (!scl) begin
      ack <= 1'b0;
    end
  end
  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  dev_stable_a:
    assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device moved sda while scl high");
  stop_first_a:
    assert property (start |-> !in_frame)
    else $error("start without stop");
  byte_len_a:
    assert property (stop && in_frame |-> cnt == 4'h1)
    else $error("stop inside a byte");
  host_release_a:
    assert property (ack && !ack_rd |-> !host_sda_oe)
    else $error("host held sda in ack slot");
  ack_low_a:
    assert property (ack && !ack_rd && !ack_ign |-> !sda)
    else $error("missing acknowledge");
  uvlo_quiet_a:
    assert property (lock && in_frame |-> !dev_sda_oe)
    else $error("device drove sda in lockout");
  addr_ignore_a:
    assert property (ign |-> !dev_sda_oe)
    else $error("device drove sda when not addressed");
  rd_release_a:
    assert property (ack && ack_rd |-> !dev_sda_oe)
    else $error("device held sda in host ack");
  nack_stop_a:
    assert property ($rose(ack) && ack_rd && sda |-> ##[1:64] stop)
    else $error("no stop after read nack");
endmodule

// >>> dv/tb_i2c_register_slave_port.sv
// Bench joining both ends over the two-wire link.
// Assumes package, interface and both ends compiled before it.
`timescale 1ns/100ps
`include "i2crs_params.svh"

module tb_i2c_register_slave_port;
  import i2crs_pkg::*;
  localparam logic [6:0] CHIP = `I2CRS_SLAVE_ADDR;
  logic clk_in, rst_in, uvlo, aw_v, w_v, b_r, ar_v, r_r;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, dev_busy;
  logic [7:0] aw_a, ar_a;
  logic [31:0] w_d, r_d, got;
  logic [1:0] b_resp, r_resp, resp;
  i2crs_status_t st;
  i2crs_ctrl_t ctrl;
  int fails, checked;
  i2crs_if link ();
  i2crs_host u_i2crs_host (.clk_in(clk_in), .rst_in(rst_in),
    .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v),
    .s_axi_awready_out(aw_rdy), .s_axi_wdata_in(w_d),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w_v),
    .s_axi_wready_out(w_rdy), .s_axi_bresp_out(b_resp),
    .s_axi_bvalid_out(b_v), .s_axi_bready_in(b_r),
    .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v),
    .s_axi_arready_out(ar_rdy), .s_axi_rdata_out(r_d),
    .s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_v),
    .s_axi_rready_in(r_r), .link(link));
  i2crs_device #(.SLAVE_ADDR(CHIP)) u_i2crs_device (.clk_in(clk_in),
    .rst_in(rst_in), .link(link), .uvlo_in(uvlo), .status_in(st),
    .control_out(ctrl), .busy_out(dev_busy));
  i2crs_asserts #(.SLAVE_ADDR(CHIP)) u_i2crs_asserts (.clk_in(clk_in),
    .rst_in(rst_in), .scl(link.scl), .sda(link.sda),
    .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe),
    .uvlo_in(uvlo));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic finish_test();
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Ready lines stay high, so every answer is taken when it shows
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    do begin
      @(posedge clk_in);
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
    end while (b_v !== 1'b1);
    chk({30'h0, b_resp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    ar_a <= a;
    ar_v <= 1'b1;
    do begin
      @(posedge clk_in);
      if (ar_rdy) ar_v <= 1'b0;
    end while (r_v !== 1'b1);
    d = r_d;
    r = r_resp;
  endtask

  task automatic xfer(input logic [6:0] chip, input logic [7:0] ptr,
    input logic rdn, input logic [1:0] len, input logic [31:0] d,
    input logic nack);
    logic seen;
    wr(`I2CRS_REG_WDATA, d, `I2CRS_RESP_OKAY);
    wr(`I2CRS_REG_TARGET, {16'h0, ptr, 1'b0, chip}, `I2CRS_RESP_OKAY);
    wr(`I2CRS_REG_CTRL, {28'h0, len, rdn, 1'b1}, `I2CRS_RESP_OKAY);
    got = 32'h1;
    seen = 1'b0;
    while (got[`I2CRS_STATUS_BUSY] !== 1'b0) begin
      rd(`I2CRS_REG_STATUS, got, resp);
      seen = seen | dev_busy;
    end
    chk({31'h0, got[`I2CRS_STATUS_NACK]}, {31'h0, nack});
    chk({31'h0, seen}, 32'h1);
    rd(`I2CRS_REG_RDATA, got, resp);
    chk({30'h0, resp}, {30'h0, `I2CRS_RESP_OKAY});
    chk({31'h0, dev_busy}, 32'h0);
  endtask

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  initial begin
    #2000000;
    fails++;
    finish_test();
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    uvlo = 1'b0;
    {aw_v, w_v, ar_v} = 3'h0;
    {b_r, r_r} = 2'h3;
    aw_a = 8'h00;
    ar_a = 8'h00;
    w_d = 32'h0;
    st = 16'hc35a;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    chk(ctrl, 32'h0);
    xfer(CHIP, 8'h02, 1'b0, 2'd3, 32'h44332211, 1'b0);
    chk(ctrl, 32'h44332211);
    xfer(CHIP, 8'h04, 1'b0, 2'd0, 32'h000000a5, 1'b0);
    chk(ctrl, 32'h44a52211);
    xfer(CHIP, 8'h00, 1'b1, 2'd3, 32'h0, 1'b0);
    chk(got, 32'h2211c35a);
    xfer(CHIP, 8'h04, 1'b1, 2'd2, 32'h0, 1'b0);
    chk({8'h0, got[23:0]}, 32'h000044a5);
    xfer(CHIP ^ 7'h01, 8'h02, 1'b0, 2'd0, 32'hff, 1'b1);
    chk(ctrl, 32'h44a52211);
    uvlo <= 1'b1;
    repeat (4) @(posedge clk_in);
    xfer(CHIP, 8'h02, 1'b0, 2'd0, 32'hff, 1'b1);
    chk(ctrl, 32'h44a52211);
    uvlo <= 1'b0;
    wr(8'h20, 32'h1, `I2CRS_RESP_SLVERR);
    rd(8'h20, got, resp);
    chk(got, 32'h0);
    chk({30'h0, resp}, {30'h0, `I2CRS_RESP_SLVERR});
    finish_test();
  end
endmodule
